// ==== hdl/swc_pkg.sv ====
// Package: offsets, field layout and port-width encodings for the station width register
package swc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] SWC_CFG_OFFSET   = 12'h574;
  localparam logic [11:0] SWC_RANGE_LO     = 12'h54c;
  localparam logic [11:0] SWC_RANGE_HI     = 12'hf8c;
  localparam logic [7:0]  SWC_HOME_PORT    = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SWC_STN0_LSB  = 0;
  localparam int SWC_STN1_LSB  = 2;
  localparam int SWC_STN2_LSB  = 4;
  localparam int SWC_NX2_LSB   = 20;
  localparam int SWC_NX2_W     = 4;
  localparam int SWC_STATIONS  = 3;

  // ****************************************
  // Width codes and fixed bits
  // ****************************************
  localparam logic [1:0]  SWC_CODE_X8      = 2'h2;
  localparam logic [1:0]  SWC_CODE_SPLIT0  = 2'h0;
  localparam logic [1:0]  SWC_CODE_SPLIT1  = 2'h3;
  localparam logic        SWC_STN0_FIXED   = 1'h0;
  localparam logic        SWC_STN1_FIXED   = 1'h1;
  localparam logic        SWC_STN2_FIXED   = 1'h0;
  localparam logic [3:0]  SWC_NX2_RESET    = 4'h0;

  // Per-port lane width driven to the link layer
  typedef enum logic [1:0] {
    SWC_W_OFF = 2'h0,
    SWC_W_X4  = 2'h1,
    SWC_W_X8  = 2'h2,
    SWC_W_SW  = 2'h3
  } swc_width_t;

  // Serial loader write into the register
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } swc_load_t;

  // Configuration read request
  typedef struct packed {
    logic        valid;
    logic [7:0]  port;
    logic        iso_vif;
    logic [11:0] offset;
  } swc_rd_req_t;

  // Widths of the seven station ports: 0,1,4,5,6 in station order, then 8,9
  typedef struct packed {
    swc_width_t p0;
    swc_width_t p1;
    swc_width_t p4;
    swc_width_t p5;
    swc_width_t p6;
    swc_width_t p8;
    swc_width_t p9;
  } swc_port_widths_t;

endpackage

// ==== hdl/swc_station_width_config.sv ====
// Station link-width configuration register with strap capture and serial load override
// ****************************************
// ****************************************
`timescale 1ns/1ps
module swc_station_width_config #(
  parameter int NX2_W = swc_pkg::SWC_NX2_W
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     fundamental_reset_in,
  input  wire logic                     station0_width_strap,
  input  wire logic                     station1_width_strap,
  input  wire logic                     station2_width_strap,
  input  wire logic                     port0_is_isolating,
  input  wire swc_pkg::swc_load_t       load_in,
  input  wire swc_pkg::swc_rd_req_t     rd_req,
  input  wire logic                     sw_wr_valid,
  input  wire logic [11:0]              sw_wr_offset,
  input  wire logic [31:0]              sw_wr_data,
  output logic                          rd_ack,
  output logic                          rd_hit,
  output logic [31:0]                   rd_data,
  output logic [31:0]                   cfg_value,
  output swc_pkg::swc_port_widths_t     port_widths
);

  // ****************************************
  // Parameter check
  // ****************************************
  initial begin
    if (NX2_W != swc_pkg::SWC_NX2_W) begin
      $error("swc_station_width_config: NX2_W must match the register layout");
    end
  end

  // ****************************************
  // Strap synchronisation
  // ****************************************
  // Fundamental reset arrives from a pin, so it is synchronised with the straps
  logic [3:0] pins_sync;

  swc_strap_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (clk),
    .srst     (1'b0),
    .async_in ({fundamental_reset_in, station2_width_strap, station1_width_strap, station0_width_strap}),
    .sync_out (pins_sync)
  );

  wire logic fund_rst = pins_sync[3];

  // ****************************************
  // Width field state
  // ****************************************
  logic [1:0]       stn0_reg;
  logic [1:0]       stn1_reg;
  logic [1:0]       stn2_reg;
  logic [3*NX2_W-1:0] nx2_reg;

  // Strap-derived codes with the fixed bit in place
  wire logic [1:0] stn0_strap = {pins_sync[0], swc_pkg::SWC_STN0_FIXED};
  wire logic [1:0] stn1_strap = {swc_pkg::SWC_STN1_FIXED, pins_sync[1]};
  wire logic [1:0] stn2_strap = {pins_sync[2], swc_pkg::SWC_STN2_FIXED};

  // Loader keeps fixed bits; a reserved code cannot be stored that way
  wire logic [1:0] stn0_load = {load_in.data[swc_pkg::SWC_STN0_LSB+1], swc_pkg::SWC_STN0_FIXED};
  wire logic [1:0] stn1_load = {swc_pkg::SWC_STN1_FIXED, load_in.data[swc_pkg::SWC_STN1_LSB]};
  wire logic [1:0] stn2_load = {load_in.data[swc_pkg::SWC_STN2_LSB+1], swc_pkg::SWC_STN2_FIXED};

  // Software writes are decoded but have no effect on read-only fields
  wire logic sw_wr_hit = sw_wr_valid && (sw_wr_offset == swc_pkg::SWC_CFG_OFFSET);

  wire logic [1:0] stn0_next = load_in.valid ? stn0_load : stn0_reg;
  wire logic [1:0] stn1_next = load_in.valid ? stn1_load : stn1_reg;
  wire logic [1:0] stn2_next = load_in.valid ? stn2_load : stn2_reg;
  wire logic [3*NX2_W-1:0] nx2_next =
    load_in.valid ? load_in.data[swc_pkg::SWC_NX2_LSB +: 3*NX2_W] : nx2_reg;

  // Fundamental reset reloads the straps; srst is deliberately ignored here
  always_ff @(posedge clk) begin
    if (fund_rst) begin
      stn0_reg <= stn0_strap;
      stn1_reg <= stn1_strap;
      stn2_reg <= stn2_strap;
      nx2_reg  <= {3{swc_pkg::SWC_NX2_RESET}};
    end else begin
      stn0_reg <= stn0_next;
      stn1_reg <= stn1_next;
      stn2_reg <= stn2_next;
      nx2_reg  <= nx2_next;
    end
  end

  // ****************************************
  // Register image
  // ****************************************
  // Bits 19:6 are constant zero
  wire logic [31:0] reg_image = {nx2_reg, 14'h0000, stn2_reg, stn1_reg, stn0_reg};

  // ****************************************
  // Read decode
  // ****************************************
  function automatic logic space_ok(input logic [7:0] port, input logic iso_vif, input logic iso_role);
    space_ok = iso_vif ? iso_role : (port == swc_pkg::SWC_HOME_PORT);
  endfunction

  wire logic rd_hit_next = rd_req.valid &&
                           space_ok(rd_req.port, rd_req.iso_vif, port0_is_isolating) &&
                           (rd_req.offset == swc_pkg::SWC_CFG_OFFSET);

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_ack  <= 1'b0;
      rd_hit  <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      rd_ack  <= rd_req.valid;
      rd_hit  <= rd_hit_next;
      rd_data <= rd_hit_next ? reg_image : 32'h0000_0000;
    end
  end

  assign cfg_value = reg_image;

  // ****************************************
  // Port width decode
  // ****************************************
  function automatic logic is_split(input logic [1:0] code, input logic [1:0] split_code);
    is_split = (code == split_code);
  endfunction

  wire logic s0_split = is_split(stn0_reg, swc_pkg::SWC_CODE_SPLIT0);
  wire logic s1_split = is_split(stn1_reg, swc_pkg::SWC_CODE_SPLIT1);
  wire logic s2_split = is_split(stn2_reg, swc_pkg::SWC_CODE_SPLIT0);

  // Reserved codes are unreachable, so not split means x8
  assign port_widths.p0 = s0_split ? swc_pkg::SWC_W_X4 : swc_pkg::SWC_W_X8;
  assign port_widths.p1 = s0_split ? swc_pkg::SWC_W_X4 : swc_pkg::SWC_W_OFF;
  assign port_widths.p4 = swc_pkg::SWC_W_SW;
  assign port_widths.p5 = s1_split ? swc_pkg::SWC_W_X4 : swc_pkg::SWC_W_X8;
  assign port_widths.p6 = s1_split ? swc_pkg::SWC_W_X4 : swc_pkg::SWC_W_OFF;
  assign port_widths.p8 = s2_split ? swc_pkg::SWC_W_X4 : swc_pkg::SWC_W_X8;
  assign port_widths.p9 = s2_split ? swc_pkg::SWC_W_X4 : swc_pkg::SWC_W_OFF;

endmodule

// ==== hdl/swc_strap_sync.sv ====
// Two-stage synchroniser for the station width strap pins
`timescale 1ns/1ps
module swc_strap_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("swc_strap_sync: WIDTH must be at least 1");
    end
  end

  // Meta stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ==== test/swc_checker.sv ====
// Checker: port-level properties of the station width register
`timescale 1ns/1ps
module swc_checker (
  input wire logic                      clk,
  input wire logic                      srst,
  input wire logic                      fundamental_reset_in,
  input wire logic                      station0_width_strap,
  input wire logic                      station1_width_strap,
  input wire logic                      station2_width_strap,
  input wire logic                      port0_is_isolating,
  input wire swc_pkg::swc_load_t        load_in,
  input wire swc_pkg::swc_rd_req_t      rd_req,
  input wire logic                      rd_ack,
  input wire logic                      rd_hit,
  input wire logic [31:0]               rd_data,
  input wire logic [31:0]               cfg_value,
  input wire swc_pkg::swc_port_widths_t port_widths
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire hit_w = rd_req.offset == swc_pkg::SWC_CFG_OFFSET &&
               (rd_req.iso_vif ? port0_is_isolating : rd_req.port == swc_pkg::SWC_HOME_PORT);
  property p_ack; rd_req.valid |=> rd_ack; endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  property p_quiet; !rd_req.valid |=> !rd_ack; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_hit; rd_req.valid |=> rd_hit == $past(hit_w) && rd_data == ($past(hit_w) ? $past(cfg_value) : 32'h0); endproperty
  a_hit: assert property (p_hit) else $error("read decode wrong");
  property p_fixed; cfg_value[19:6] == 14'h0 && cfg_value[4:3] == 2'h1 && !cfg_value[0]; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
  property p_load; (!fundamental_reset_in)[*4] ##0 load_in.valid |=> cfg_value == (($past(load_in.data) & 32'hfff00026) | 32'h8); endproperty
  a_load: assert property (p_load) else $error("load not applied");
  property p_frst; fundamental_reset_in[*6] |-> cfg_value == {26'h0, station2_width_strap, 2'h1, station1_width_strap, station0_width_strap, 1'b0}; endproperty
  a_frst: assert property (p_frst) else $error("strap image wrong");
  property p_hold; (!fundamental_reset_in)[*4] ##0 !load_in.valid |=> $stable(cfg_value); endproperty
  a_hold: assert property (p_hold) else $error("fields changed");
  property p_stn0; port_widths[13:10] == (cfg_value[1] ? 4'h8 : 4'h5); endproperty
  a_stn0: assert property (p_stn0) else $error("station 0 widths wrong");
  property p_stn1; port_widths[9:4] == (cfg_value[2] ? 6'h35 : 6'h38); endproperty
  a_stn1: assert property (p_stn1) else $error("station 1 widths wrong");
  property p_stn2; port_widths[3:0] == (cfg_value[5] ? 4'h8 : 4'h5); endproperty
  a_stn2: assert property (p_stn2) else $error("station 2 widths wrong");
  c_hit: cover property (rd_ack && rd_hit);
  c_miss: cover property (rd_ack && !rd_hit);
  c_load: cover property (load_in.valid && !fundamental_reset_in);
endmodule
bind swc_station_width_config swc_checker chk_u (.clk(clk), .srst(srst), .fundamental_reset_in(fundamental_reset_in),
  .station0_width_strap(station0_width_strap), .station1_width_strap(station1_width_strap),
  .station2_width_strap(station2_width_strap), .port0_is_isolating(port0_is_isolating), .load_in(load_in),
  .rd_req(rd_req), .rd_ack(rd_ack), .rd_hit(rd_hit), .rd_data(rd_data), .cfg_value(cfg_value), .port_widths(port_widths));

// ==== test/swc_partner.sv ====
// Partner: strap pins and serial configuration loader
`timescale 1ns/1ps
module swc_partner (
  input  wire logic          clk,
  output logic [2:0]         straps,
  output swc_pkg::swc_load_t load_in
);
  initial begin
    straps = 3'h0;
    load_in = '0;
  end
  // Straps move well before a reset so capture never sees an edge
  task automatic strap(input logic [2:0] s);
    straps = s;
  endtask
  // Loader only ever writes this one register, leaving the range at defaults
  task automatic load(input logic [31:0] w);
    @(posedge clk);
    #1 load_in = '{valid: 1'b1, data: w};
    @(posedge clk);
    #1 load_in.valid = 1'b0;
  endtask
endmodule

// ==== test/tb_top.sv ====
// Testbench: strap capture, serial load, read decode and reset behaviour
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, srst = 1'b1, frst = 1'b1, iso = 1'b0, sw_v = 1'b0;
  logic [2:0]                straps;
  logic                      rd_ack, rd_hit;
  logic [31:0]               rd_data, cfg;
  swc_pkg::swc_load_t        load_in;
  swc_pkg::swc_rd_req_t      rd_req = '0;
  swc_pkg::swc_port_widths_t pw;
  int                        err_total = 0, total_checks = 0;
  always #5 clk = ~clk;
  swc_partner part_u (.clk(clk), .straps(straps), .load_in(load_in));
  swc_station_width_config dut_u (.clk(clk), .srst(srst), .fundamental_reset_in(frst), .station0_width_strap(straps[0]),
    .station1_width_strap(straps[1]), .station2_width_strap(straps[2]), .port0_is_isolating(iso), .load_in(load_in),
    .rd_req(rd_req), .sw_wr_valid(sw_v), .sw_wr_offset(swc_pkg::SWC_CFG_OFFSET), .sw_wr_data(32'hffff_ffff),
    .rd_ack(rd_ack), .rd_hit(rd_hit), .rd_data(rd_data), .cfg_value(cfg), .port_widths(pw));
  // ********
  // Helpers
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] img(input logic [2:0] s);
    return {26'h0, s[2], 2'h1, s[1], s[0], 1'b0};
  endfunction
  // Port 4 always software-only; unsplit pairs are x8 then off
  function automatic logic [31:0] epw(input logic [31:0] c);
    return {18'h0, c[1] ? 4'h8 : 4'h5, 2'h3, c[2] ? 4'h5 : 4'h8, c[5] ? 4'h8 : 4'h5};
  endfunction
  task automatic rd(input logic [7:0] p, input logic v, input logic [11:0] o, input logic h, input logic [31:0] d);
    @(posedge clk);
    #1 rd_req = '{valid: 1'b1, port: p, iso_vif: v, offset: o};
    @(posedge clk);
    #1 rd_req.valid = 1'b0;
    chk({31'h0, rd_ack}, 32'h1);
    chk({31'h0, rd_hit}, {31'h0, h});
    chk(rd_data, d);
  endtask
  task automatic fund(input logic [2:0] s);
    part_u.strap(s);
    repeat (4) @(posedge clk);
    #1 frst = 1'b1;
    repeat (6) @(posedge clk);
    #1 frst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    #100000;
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 frst = 1'b0;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    chk(cfg, img(3'h0));
    for (int i = 0; i < 8; i++) begin
      fund(i[2:0]);
      chk(cfg, img(i[2:0]));
      chk({18'h0, pw}, epw(img(i[2:0])));
    end
    part_u.load(32'hffffffff);
    chk(cfg, 32'hfff0002e);
    chk({18'h0, pw}, epw(32'h2e));
    @(posedge clk);
    #1 sw_v = 1'b1;
    @(posedge clk);
    #1 sw_v = 1'b0;
    rd(8'h00, 1'b0, 12'h574, 1'b1, 32'hfff0002e);
    rd(8'h01, 1'b0, 12'h574, 1'b0, 32'h0);
    rd(8'h00, 1'b0, 12'h578, 1'b0, 32'h0);
    rd(8'h05, 1'b1, 12'h574, 1'b0, 32'h0);
    iso = 1'b1;
    rd(8'h05, 1'b1, 12'h574, 1'b1, 32'hfff0002e);
    part_u.load(32'h5a5a5a5a);
    chk(cfg, 32'h5a50000a);
    // Read offered during sync reset must stay unanswered
    srst = 1'b1;
    rd_req = '{valid: 1'b1, port: 8'h00, iso_vif: 1'b0, offset: swc_pkg::SWC_CFG_OFFSET};
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    rd_req.valid = 1'b0;
    chk({31'h0, rd_ack}, 32'h0);
    chk(rd_data, 32'h0);
    chk(cfg, 32'h5a50000a);
    // Load lands after the synced fundamental reset is active, so it must lose
    frst = 1'b1;
    repeat (3) @(posedge clk);
    part_u.load(32'h0);
    chk(cfg, img(3'h7));
    repeat (2) @(posedge clk);
    #1 frst = 1'b0;
    repeat (4) @(posedge clk);
    chk(cfg, img(3'h7));
    print_verdict;
  end
endmodule
